// [gpiop_board.sv]
// board circuitry model on the port pins
`timescale 1ns/1ps
module gpiop_board (
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] ext_drv,
	output logic [7:0] pin_in
);
	// board drives released pins only, never fights an enabled driver
	assign pin_in = (pin_out & ~pin_oe_n) | (ext_drv & pin_oe_n);
endmodule : gpiop_board

// [gpiop_pkg.sv]
// package for the general purpose io port: offsets, reset values, states
package gpiop_pkg;
	// printed offsets 0x12 and 0x13 are not multiples of four: they are word indices
	localparam logic [7:0] GPIOP_DIR_INDEX = 8'h12;
	localparam logic [7:0] GPIOP_DATA_INDEX = 8'h13;
	// command register holding bit set, clear and toggle requests
	localparam logic [7:0] GPIOP_BITOP_INDEX = 8'h14;
	localparam logic [9:0] GPIOP_DIR_ADDR = {GPIOP_DIR_INDEX, 2'b00};
	localparam logic [9:0] GPIOP_DATA_ADDR = {GPIOP_DATA_INDEX, 2'b00};
	localparam logic [9:0] GPIOP_BITOP_ADDR = {GPIOP_BITOP_INDEX, 2'b00};
	localparam int GPIOP_WIDTH = 8;
	localparam logic [7:0] GPIOP_DIR_RESET = 8'hff;
	localparam logic [7:0] GPIOP_LATCH_POR = 8'h00;
	// bit operation field layout in the command word
	localparam int GPIOP_OP_LSB = 8;
	localparam int GPIOP_SEL_MSB = 2;
	localparam logic [1:0] GPIOP_OP_NONE = 2'b00;
	localparam logic [1:0] GPIOP_OP_SET = 2'b01;
	localparam logic [1:0] GPIOP_OP_CLEAR = 2'b10;
	localparam logic [1:0] GPIOP_OP_TOGGLE = 2'b11;
	localparam logic [1:0] GPIOP_RESP_OKAY = 2'b00;
	localparam logic [1:0] GPIOP_RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		GPIOP_W_IDLE = 2'b00,
		GPIOP_W_RESP = 2'b01
	} gpiop_wstate_e;
endpackage : gpiop_pkg

// [gpiop_port.sv]
// general purpose io port with axi4-lite register access
//
// Summary of operation
// [RULE1] eight two-way pins, each with own direction bit and latch bit
// [RULE2] direction one means input, driver off; zero means driven output
// [RULE3] reading the data register returns sampled pin levels, not latches
// [RULE4] writing the data register loads all latches regardless of direction
// [RULE5] bit set, clear, toggle read pins, modify one bit, write whole byte
// [RULE6] latch changes at end of write; pins sampled at start of read
// [RULE7] software should leave one idle access between write and read-back
// [RULE8] pins carry only digital general purpose io, no alternate function
// [RULE9] any reset sets direction to all ones; latches kept on warm reset
// [RULE10] output pins drive the latch value from the next clock edge
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
module gpiop_port
	import gpiop_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_n,
	input wire logic [9:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [9:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe_n
);
	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] latch;
		logic aw_held;
		logic [9:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		gpiop_wstate_e wstate;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] pin_out;
		logic [7:0] pin_oe_n;
	} gpiop_state_s;

	gpiop_state_s st;
	gpiop_state_s next_st;
	logic do_write;
	logic do_read;
	logic [7:0] rmw;
	logic [2:0] sel;
	logic [1:0] op;

	// write channels are held until both have arrived
	assign do_write = st.aw_held && st.w_held && (st.wstate == GPIOP_W_IDLE);
	assign do_read = s_axi_arvalid && !st.rvalid;
	assign sel = st.w_data[GPIOP_SEL_MSB:0];
	assign op = st.w_data[GPIOP_OP_LSB+1:GPIOP_OP_LSB];

	// modify acts on pin levels, so input latches take the pin value
	always_comb begin
		rmw = pin_in; // RULE5
		case (op)
			GPIOP_OP_SET: rmw[sel] = 1'b1; // RULE5
			GPIOP_OP_CLEAR: rmw[sel] = 1'b0; // RULE5
			GPIOP_OP_TOGGLE: rmw[sel] = ~pin_in[sel]; // RULE5
			default: rmw = st.latch;
		endcase
	end

	// next state of the whole slave and port
	always_comb begin
		next_st = st;
		if (!st.aw_held && s_axi_awvalid) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (!st.w_held && s_axi_wvalid) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.wstate = GPIOP_W_RESP;
			next_st.bresp = GPIOP_RESP_OKAY;
			// byte lane zero carries direction and data; bit operations need lane one
			if (st.aw_addr[9:2] == GPIOP_DIR_INDEX) begin
				if (st.w_strb[0]) next_st.dir = st.w_data[7:0]; // RULE2
			end else if (st.aw_addr[9:2] == GPIOP_DATA_INDEX) begin
				if (st.w_strb[0]) next_st.latch = st.w_data[7:0]; // RULE4 RULE6
			end else if (st.aw_addr[9:2] == GPIOP_BITOP_INDEX) begin
				if (st.w_strb[1] && op != GPIOP_OP_NONE) next_st.latch = rmw; // RULE5
			end else begin
				next_st.bresp = GPIOP_RESP_SLVERR;
			end
		end
		if (st.wstate == GPIOP_W_RESP && s_axi_bready) begin
			next_st.wstate = GPIOP_W_IDLE;
		end
		// pins sampled in the cycle the address is taken
		if (do_read) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = GPIOP_RESP_OKAY;
			next_st.rdata = 32'h0000_0000;
			if (s_axi_araddr[9:2] == GPIOP_DIR_INDEX) begin
				next_st.rdata[7:0] = st.dir;
			end else if (s_axi_araddr[9:2] == GPIOP_DATA_INDEX) begin
				next_st.rdata[7:0] = pin_in; // RULE3 RULE6
			end else if (s_axi_araddr[9:2] == GPIOP_BITOP_INDEX) begin
				next_st.rdata = 32'h0000_0000;
			end else begin
				next_st.rresp = GPIOP_RESP_SLVERR;
			end
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		// pure digital pads: no alternate function muxed in
		next_st.pin_out = next_st.latch; // RULE8 RULE10
		next_st.pin_oe_n = next_st.dir; // RULE1 RULE2
	end

	// warm reset keeps latches; only power-on clears them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.dir <= GPIOP_DIR_RESET; // RULE9
			st.pin_oe_n <= GPIOP_DIR_RESET; // RULE9
			st.latch <= por_n ? st.latch : GPIOP_LATCH_POR; // RULE9
			st.pin_out <= por_n ? st.latch : GPIOP_LATCH_POR;
			st.wstate <= GPIOP_W_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_awready = !st.aw_held;
	assign s_axi_wready = !st.w_held;
	assign s_axi_bvalid = (st.wstate == GPIOP_W_RESP);
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign pin_out = st.pin_out;
	assign pin_oe_n = st.pin_oe_n;

	// direction write shows on enables one edge later
	dir_follow_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
		do_write && st.aw_addr[9:2] == GPIOP_DIR_INDEX && st.w_strb[0]
		|=> pin_oe_n == $past(st.w_data[7:0]))
		else $error("direction not applied");
	data_latch_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
		do_write && st.aw_addr[9:2] == GPIOP_DATA_INDEX && st.w_strb[0]
		|=> pin_out == $past(st.w_data[7:0]))
		else $error("data write not latched");
	// a stray address must leave pins and directions alone
	unmapped_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
		do_write && st.aw_addr[9:2] != GPIOP_DIR_INDEX
		&& st.aw_addr[9:2] != GPIOP_DATA_INDEX && st.aw_addr[9:2] != GPIOP_BITOP_INDEX
		|=> $stable(pin_out) && $stable(pin_oe_n) && s_axi_bresp == GPIOP_RESP_SLVERR)
		else $error("unmapped write had an effect");
	// pins sampled in the cycle the read address is taken
	read_pins_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
		do_read && s_axi_araddr[9:2] == GPIOP_DATA_INDEX
		|=> s_axi_rvalid && s_axi_rdata[7:0] == $past(pin_in))
		else $error("read did not return pin levels");
	read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read address taken without an answer");
	// bit operations start from pin levels, so input latches follow the pins
	rmw_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
		do_write && st.aw_addr[9:2] == GPIOP_BITOP_INDEX && st.w_strb[1]
		&& op == GPIOP_OP_SET |=> pin_out[$past(sel)] == 1'b1)
		else $error("bit set failed");
	rmw_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
		do_write && st.aw_addr[9:2] == GPIOP_BITOP_INDEX && st.w_strb[1]
		&& op == GPIOP_OP_CLEAR |=> pin_out[$past(sel)] == 1'b0)
		else $error("bit clear failed");
	rmw_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
		do_write && st.aw_addr[9:2] == GPIOP_BITOP_INDEX && st.w_strb[1]
		&& op == GPIOP_OP_TOGGLE |=> pin_out[$past(sel)] == ~$past(pin_in[sel]))
		else $error("bit toggle failed");
	rmw_pins_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
		do_write && st.aw_addr[9:2] == GPIOP_BITOP_INDEX && st.w_strb[1]
		&& op != GPIOP_OP_NONE |=> (pin_out & ~(8'h01 << $past(sel)))
		== ($past(pin_in) & ~(8'h01 << $past(sel))))
		else $error("bit operation did not use pin levels");
	// any reset turns every pin back into an input
	reset_dir_a: assert property (@(posedge aclk) // RULE9
		!aresetn |=> pin_oe_n == GPIOP_DIR_RESET)
		else $error("direction not all inputs after reset");
	// warm reset keeps the latches, power-on clears them
	warm_keep_a: assert property (@(posedge aclk) // RULE9
		!aresetn && por_n |=> pin_out == $past(pin_out))
		else $error("latch lost on warm reset");
	por_clear_a: assert property (@(posedge aclk) // RULE9
		!aresetn && !por_n |=> pin_out == GPIOP_LATCH_POR)
		else $error("latch not cleared on power-on reset");
	// pads show exactly what the latch and direction hold
	out_match_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
		pin_out == st.latch && pin_oe_n == st.dir)
		else $error("pins disagree with latch or direction");
	// a late master must still find the answer standing
	bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rhold_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule : gpiop_port

// [gpiop_port_tb_top.sv]
// self-checking testbench for the io port
`timescale 1ns/1ps
module gpiop_port_tb_top
	import gpiop_pkg::*;
;
	logic aclk = 0, aresetn = 0, por_n = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
	logic [9:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, d;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, r, b;
	logic [7:0] ext = 8'hc3, pin_in, pin_out, pin_oe_n, lat = 8'h00, dir = 8'hff, p;
	int err_total = 0, n_compared = 0, lag = 0;
	always #50 aclk = ~aclk;
	gpiop_port u_gpiop_port (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n));
	gpiop_board u_gpiop_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_drv(ext),
		.pin_in(pin_in));
	// expected pin levels from the tracked latch and direction
	function automatic logic [7:0] pexp();
		return (dir & ext) | (~dir & lat);
	endfunction : pexp
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// idle cycles first so pin levels settle between accesses
	task automatic wr(input logic [9:0] a, input logic [31:0] v);
		logic ap;
		logic wp;
		repeat (3) @(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= (lag == 0);
		ap = 1'b1;
		wp = 1'b1;
		while (ap | wp) begin
			@(posedge aclk);
			if (ap && awready === 1'b1) begin
				awvalid <= 1'b0;
				ap = 1'b0;
			end
			if (wp && wready === 1'b1) begin
				wvalid <= 1'b0;
				wp = 1'b0;
			end
		end
		// a nonzero lag keeps bready low so the response has to stand
		repeat (lag) @(posedge aclk);
		bready <= 1'b1;
		do begin
			@(posedge aclk);
		end while (bvalid !== 1'b1);
		b = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [9:0] a);
		repeat (3) @(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= (lag == 0);
		do begin
			@(posedge aclk);
		end while (arready !== 1'b1);
		arvalid <= 1'b0;
		repeat (lag) @(posedge aclk);
		rready <= 1'b1;
		do begin
			@(posedge aclk);
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic t_reset();
		chk(pin_out, 8'h00);
		chk(pin_oe_n, 8'hff);
		rd(GPIOP_DIR_ADDR);
		chk(d, 32'h0000_00ff);
		$display("test reset done");
	endtask : t_reset
	task automatic t_latch();
		wr(GPIOP_DATA_ADDR, 32'h0000_005a);
		lat = 8'h5a;
		chk(b, GPIOP_RESP_OKAY);
		chk(pin_out, lat);
		rd(GPIOP_DATA_ADDR);
		chk(d, 32'h0000_00c3);
		chk(r, GPIOP_RESP_OKAY);
		wr(GPIOP_DIR_ADDR, 32'h0000_000f);
		dir = 8'h0f;
		chk(pin_oe_n, dir);
		rd(GPIOP_DATA_ADDR);
		chk(d, {24'h0, pexp()});
		$display("test latch done");
	endtask : t_latch
	// set bit 3 (input pin), clear bit 6 (latch high), toggle bit 7, all from pin levels
	task automatic t_bitop();
		logic [2:0] s;
		for (int op = 1; op < 4; op++) begin
			s = (op == 1) ? 3'h3 : ((op == 2) ? 3'h6 : 3'h7);
			p = pexp();
			if (op == 1) p[s] = 1'b1;
			if (op == 2) p[s] = 1'b0;
			if (op == 3) p[s] = ~p[s];
			wr(GPIOP_BITOP_ADDR, {22'h00_0000, op[1:0], 5'h00, s});
			lat = p;
			chk(pin_out, lat);
		end
		$display("test bitop done");
	endtask : t_bitop
	// stray addresses answer with an error and change nothing
	task automatic t_unmap();
		rd(10'h3fc);
		chk(d, 32'h0000_0000);
		chk(r, GPIOP_RESP_SLVERR);
		rd(GPIOP_BITOP_ADDR);
		chk(d, 32'h0000_0000);
		chk(r, GPIOP_RESP_OKAY);
		wr(10'h3fc, 32'h0000_00ff);
		chk(b, GPIOP_RESP_SLVERR);
		chk(pin_out, lat);
		chk(pin_oe_n, dir);
		$display("test unmapped done");
	endtask : t_unmap
	// master answers late: response and read data must wait for it
	task automatic t_stall();
		lag = 3;
		wr(GPIOP_DATA_ADDR, 32'h0000_00a5);
		lat = 8'ha5;
		chk(b, GPIOP_RESP_OKAY);
		chk(pin_out, lat);
		rd(GPIOP_DATA_ADDR);
		chk(d, {24'h0, pexp()});
		lag = 0;
		$display("test stalled answer done");
	endtask : t_stall
	task automatic t_warm();
		@(posedge aclk);
		aresetn <= 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		dir = GPIOP_DIR_RESET;
		@(posedge aclk);
		chk(pin_out, lat);
		chk(pin_oe_n, 8'hff);
		rd(GPIOP_DATA_ADDR);
		chk(d, {24'h0, pexp()});
		$display("test warm reset done");
	endtask : t_warm
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results
	initial begin
		#2000000;
		err_total++;
		results();
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		por_n <= 1;
		@(posedge aclk);
		t_reset();
		t_latch();
		t_bitop();
		t_unmap();
		t_stall();
		t_warm();
		results();
	end
endmodule : gpiop_port_tb_top
